/* File: src/ccp_unit.sv */
// capture/compare/pwm unit with its timer2 time base and wishbone slave
//
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps

// Overview of operation
// - timer2 is 8-bit, fed from osc/4 through a 1, 4 or 16 prescaler
// - timer2 counts up from 00h and returns to 00h after matching period
// - each timer2 match feeds a 1:1..1:16 postscaler setting timer2_flag
// - timer2 stops counting while timer2_on is clear
// - writes to count or control, and reset, clear both scalers
// - the pre-postscaler match pulse goes out to the serial port
// - unit register is 16 bits, low and high bytes readable and writable
// - capture copies timer1_count on fall, rise, 4th or 16th rise
// - a capture sets unit_event_flag until cleared; later ones overwrite
// - a port write that moves the pin may trigger a capture
// - capture prescaler is held clear when off or not capturing
// - direct switch between capture prescales keeps the count
// - compare match drives pin high, low or leaves it, and sets flag
// - writing zero to unit_control forces the output latch low
// - software interrupt compare only sets the flag
// - special trigger compare resets timer1, making a 16-bit period
// - pwm duty is copied to the high byte at cycle start; high read-only
// - pwm period is (period+1) * 4 osc * prescale
// - pwm high time is 10-bit duty * osc * prescale
// - standard resolution keeps duty_low_bits constant or zero
// - special trigger comes from mode code 1011
// - a timer1 write in the same cycle suppresses the special trigger
module ccp_unit
  import ccp_pkg::*;
#(
  parameter int T1_W = 16
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              reset,
  // wishbone slave
  input  wire ccp_wb_req_t       wbReq,
  output      logic              wbAck_r,
  output      logic [31:0]       wbDat_r,
  // timer1 link
  input  wire logic [T1_W-1:0]   timer1Count,
  input  wire logic              timer1Write,
  output      logic              specialTrig_r,
  // unit pin and serial port
  input  wire logic              unitPinIn,
  output      logic              unitPinOut_r,
  output      logic              unitPinDrive_r,
  output      logic              t2Match_r,
  // flags and enables for the interrupt controller
  output      logic [7:0]        flags_r,
  output      logic [7:0]        enables_r
);

  // ==========================================================
  // elaboration check
  if (T1_W != 16) begin : gBadWidth
    $error("timer1 width must be 16");
  end

  // ==========================================================
  // decode helpers
  function automatic logic isCap(input logic [3:0] m);
    isCap = (m[3:2] == 2'b01);
  endfunction

  function automatic logic isCmp(input logic [3:0] m);
    isCmp = (m[3:2] == 2'b10);
  endfunction

  function automatic logic isPwm(input logic [3:0] m);
    isPwm = (m[3:2] == 2'b11);
  endfunction

  function automatic logic [5:0] preTop(input logic [1:0] s);
    preTop = (s == 2'b00) ? PRE_TOP_1 :
             (s == 2'b01) ? PRE_TOP_4 : PRE_TOP_16;
  endfunction

  // ==========================================================
  // registers
  logic [7:0]  t2Cnt_r;
  logic [7:0]  t2Per_r;
  logic [7:0]  t2Ctl_r;
  logic [7:0]  valLo_r;
  logic [7:0]  valHi_r;
  logic [7:0]  uCtl_r;
  logic [5:0]  preCnt_r;
  logic [3:0]  postCnt_r;
  logic [3:0]  capPre_r;
  logic [9:0]  dutySlave_r;
  logic        pinS1_r;
  logic        pinS2_r;
  logic        pinS3_r;
  logic        pinStable_r;
  logic        eqPrev_r;

  // ==========================================================
  // bus decode: a write takes effect on the edge where ack is high
  logic [7:0] idx;
  logic       busWr;
  logic [7:0] wd;
  assign idx   = wbReq.adr[9:2];
  assign wd    = wbReq.dat[7:0];
  assign busWr = wbReq.cyc & wbReq.stb & wbReq.we & wbReq.sel[0] & wbAck_r;

  logic wrT2Cnt, wrT2Ctl, wrLo, wrHi, wrUCtl, wrFlags;
  assign wrT2Cnt = busWr & (idx == IDX_T2CNT);
  assign wrT2Ctl = busWr & (idx == IDX_T2CTL);
  assign wrLo    = busWr & (idx == IDX_VALLO);
  assign wrHi    = busWr & (idx == IDX_VALHI);
  assign wrUCtl  = busWr & (idx == IDX_UCTL);
  assign wrFlags = busWr & (idx == IDX_FLAGS);

  logic [3:0] mode;
  assign mode = uCtl_r[3:0];

  // ==========================================================
  // timer2 prescaler, count and wrap
  logic t2On, tick, wrap, qStep;
  logic [1:0] quarter;
  assign t2On = t2Ctl_r[T2_ON_BIT];
  assign tick = t2On & (preCnt_r == preTop(t2Ctl_r[1:0]));
  assign wrap = tick & (t2Cnt_r == t2Per_r);

  // quarter phase is the top two bits of the prescaler span; qStep marks
  // the edge at which the extended count moves on
  always_comb begin
    case (t2Ctl_r[1:0])
      2'b00: begin
        quarter = preCnt_r[1:0];
        qStep   = t2On;
      end
      2'b01: begin
        quarter = preCnt_r[3:2];
        qStep   = t2On & (&preCnt_r[1:0]);
      end
      default: begin
        quarter = preCnt_r[5:4];
        qStep   = t2On & (&preCnt_r[3:0]);
      end
    endcase
  end

  // prescaler: cleared by writes to count or control
  always_ff @(posedge clk) begin
    if (reset || wrT2Cnt || wrT2Ctl) begin
      preCnt_r <= 6'h00;
    end else if (tick) begin
      preCnt_r <= 6'h00;
    end else if (t2On) begin
      preCnt_r <= preCnt_r + 6'h01;
    end
  end

  // count register; software write wins over counting
  always_ff @(posedge clk) begin
    if (reset) begin
      t2Cnt_r <= RST_BYTE;
    end else if (wrT2Cnt) begin
      t2Cnt_r <= wd;
    end else if (wrap) begin
      t2Cnt_r <= 8'h00;
    end else if (tick) begin
      t2Cnt_r <= t2Cnt_r + 8'h01;
    end
  end

  // postscaler counts matches up to the selected ratio
  always_ff @(posedge clk) begin
    if (reset || wrT2Cnt || wrT2Ctl) begin
      postCnt_r <= 4'h0;
    end else if (wrap) begin
      if (postCnt_r == t2Ctl_r[T2_POST_LSB +: 4]) begin
        postCnt_r <= 4'h0;
      end else begin
        postCnt_r <= postCnt_r + 4'h1;
      end
    end
  end

  logic postDone;
  assign postDone = wrap & (postCnt_r == t2Ctl_r[T2_POST_LSB +: 4]);

  // match pulse for the serial port, one cycle per wrap
  always_ff @(posedge clk) begin
    if (reset) begin
      t2Match_r <= 1'b0;
    end else begin
      t2Match_r <= wrap;
    end
  end

  // ==========================================================
  // pin synchroniser; a level counts once stages two and three agree
  // the pin wire carries the port latch too, so port writes capture
  always_ff @(posedge clk) begin
    if (reset) begin
      pinS1_r     <= 1'b0;
      pinS2_r     <= 1'b0;
      pinS3_r     <= 1'b0;
      pinStable_r <= 1'b0;
    end else begin
      pinS1_r <= unitPinIn;
      pinS2_r <= pinS1_r;
      pinS3_r <= pinS2_r;
      if (pinS2_r == pinS3_r) begin
        pinStable_r <= pinS3_r;
      end
    end
  end

  logic pinRise, pinFall;
  assign pinRise = (pinS2_r == pinS3_r) & pinS3_r & ~pinStable_r;
  assign pinFall = (pinS2_r == pinS3_r) & ~pinS3_r & pinStable_r;

  // ==========================================================
  // capture prescaler and event selection
  logic [3:0] capTop;
  logic       capEvt;
  assign capTop = (mode == MODE_CR4) ? CAP_TOP_4 : CAP_TOP_16;

  always_comb begin
    case (mode)
      MODE_CFALL: capEvt = pinFall;
      MODE_CRISE: capEvt = pinRise;
      MODE_CR4,
      MODE_CR16:  capEvt = pinRise & (capPre_r == capTop);
      default:    capEvt = 1'b0;
    endcase
  end

  // held clear outside capture; a switch between prescales keeps it
  always_ff @(posedge clk) begin
    if (reset || !isCap(mode)) begin
      capPre_r <= 4'h0;
    end else if (pinRise) begin
      capPre_r <= (capPre_r >= capTop) ? 4'h0 :
                  capPre_r + 4'h1;
    end
  end

  // ==========================================================
  // compare: act once per arrival at equality
  logic eq, cmpHit;
  assign eq     = ({valHi_r, valLo_r} == timer1Count);
  assign cmpHit = isCmp(mode) & eq & ~eqPrev_r;

  always_ff @(posedge clk) begin
    if (reset) begin
      eqPrev_r <= 1'b0;
    end else begin
      eqPrev_r <= eq;
    end
  end

  // special trigger; a same-cycle timer1 write takes precedence
  always_ff @(posedge clk) begin
    if (reset) begin
      specialTrig_r <= 1'b0;
    end else begin
      specialTrig_r <= cmpHit & (mode == MODE_KTRIG)
                       & ~timer1Write;
    end
  end

  // ==========================================================
  // unit value bytes; hardware loads win over software writes
  always_ff @(posedge clk) begin
    if (reset) begin
      valLo_r <= RST_BYTE;
      valHi_r <= RST_BYTE;
    end else if (capEvt) begin
      {valHi_r, valLo_r} <= timer1Count;
    end else begin
      if (wrLo) begin
        valLo_r <= wd;
      end
      if (isPwm(mode) && wrap) begin
        valHi_r <= valLo_r;
      end else if (wrHi && !isPwm(mode)) begin
        valHi_r <= wd;
      end
    end
  end

  // ==========================================================
  // pwm: full 10-bit duty is latched at each cycle start
  // the latch compares the next extended count, else the high time
  // would run one clock past duty steps
  logic [9:0] dutyNew, extCnt, extNxt;
  assign dutyNew = {valLo_r, uCtl_r[UCTL_DUTY_LSB +: 2]};
  assign extCnt  = {t2Cnt_r, quarter};
  assign extNxt  = extCnt + {9'h000, qStep};

  always_ff @(posedge clk) begin
    if (reset) begin
      dutySlave_r <= 10'h000;
    end else if (isPwm(mode) && wrap) begin
      dutySlave_r <= dutyNew;
    end
  end

  // ==========================================================
  // output latch shared by compare and pwm; separate from port latch
  always_ff @(posedge clk) begin
    if (reset || (wrUCtl && wd == 8'h00) || mode == MODE_OFF) begin
      unitPinOut_r <= 1'b0;
    end else if (isPwm(mode)) begin
      if (wrap) begin
        unitPinOut_r <= (dutyNew != 10'h000);
      end else if (extNxt == dutySlave_r) begin
        unitPinOut_r <= 1'b0;
      end
    end else if (cmpHit) begin
      if (mode == MODE_KSET) begin
        unitPinOut_r <= 1'b1;
      end else if (mode == MODE_KCLR) begin
        unitPinOut_r <= 1'b0;
      end
    end
  end

  // the pin is driven by the unit in pwm mode and in the set and clear compare modes
  always_ff @(posedge clk) begin
    if (reset) begin
      unitPinDrive_r <= 1'b0;
    end else begin
      unitPinDrive_r <= isPwm(mode) |
                        (isCmp(mode) & (mode[1] == 1'b0));
    end
  end

  // ==========================================================
  // control and period registers
  always_ff @(posedge clk) begin
    if (reset) begin
      t2Ctl_r <= RST_BYTE;
      t2Per_r <= RST_T2PER;
      uCtl_r  <= RST_BYTE;
    end else begin
      if (wrT2Ctl) begin
        t2Ctl_r <= {1'b0, wd[6:0]};
      end
      if (busWr && idx == IDX_T2PER) begin
        t2Per_r <= wd;
      end
      if (wrUCtl) begin
        uCtl_r <= {2'b00, wd[5:0]};
      end
    end
  end

  // ==========================================================
  // flags: a hardware set wins over a software clear in the same cycle
  logic unitSet;
  assign unitSet = capEvt | cmpHit;

  always_ff @(posedge clk) begin
    if (reset) begin
      flags_r   <= RST_BYTE;
      enables_r <= RST_BYTE;
    end else begin
      flags_r[FLAG_T2_BIT] <= postDone |
        (wrFlags ? wd[FLAG_T2_BIT] : flags_r[FLAG_T2_BIT]);
      flags_r[FLAG_UNIT_BIT] <= unitSet |
        (wrFlags ? wd[FLAG_UNIT_BIT] : flags_r[FLAG_UNIT_BIT]);
      if (busWr && idx == IDX_ENAB) begin
        enables_r <= {5'b00000, wd[2:1], 1'b0};
      end
    end
  end

  // ==========================================================
  // wishbone answer: ack one cycle after the strobe, dropped after
  always_ff @(posedge clk) begin
    if (reset) begin
      wbAck_r <= 1'b0;
      wbDat_r <= 32'h0000_0000;
    end else begin
      wbAck_r <= wbReq.cyc & wbReq.stb & ~wbAck_r;
      case (idx)
        IDX_FLAGS: wbDat_r <= {24'h000000, flags_r};
        IDX_T2CNT: wbDat_r <= {24'h000000, t2Cnt_r};
        IDX_T2CTL: wbDat_r <= {24'h000000, t2Ctl_r};
        IDX_VALLO: wbDat_r <= {24'h000000, valLo_r};
        IDX_VALHI: wbDat_r <= {24'h000000, valHi_r};
        IDX_UCTL:  wbDat_r <= {24'h000000, uCtl_r};
        IDX_ENAB:  wbDat_r <= {24'h000000, enables_r};
        IDX_T2PER: wbDat_r <= {24'h000000, t2Per_r};
        default:   wbDat_r <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence sWrapNoWr;
    wrap && !wrT2Cnt;
  endsequence

  sequence sPwmStart;
    isPwm(mode) && wrap && !capEvt;
  endsequence

  t2_wrap_a: assert property (sWrapNoWr |=> t2Cnt_r == 8'h00)
    else $error("timer2 did not return to zero after period match");

  t2_off_a: assert property (!t2On && !wrT2Cnt |=> $stable(t2Cnt_r))
    else $error("timer2 counted while off");

  post_flag_a: assert property (postDone |=> flags_r[FLAG_T2_BIT])
    else $error("postscaler terminal count did not set timer2 flag");

  match_out_a: assert property (wrap |=> t2Match_r ##1 !t2Match_r)
    else $error("match pulse wrong");

  scaler_clr_a: assert property (wrT2Ctl |=> preCnt_r == 6'h00
                                 && postCnt_r == 4'h0)
    else $error("scalers not cleared by control write");

  cap_load_a: assert property (capEvt |=> {valHi_r, valLo_r}
           == $past(timer1Count) && flags_r[FLAG_UNIT_BIT])
    else $error("capture did not load value and flag");

  cap_pre_a: assert property (!isCap(mode) |=> capPre_r == 4'h0
                              || isCap(mode))
    else $error("capture prescaler not held clear");

  ctl_zero_a: assert property (wrUCtl && wd == 8'h00
                               |=> !unitPinOut_r [*2])
    else $error("output latch not forced low");

  sw_int_a: assert property (mode == MODE_KSOFT && !wrUCtl
                             && $stable(mode) |=> $stable(unitPinOut_r))
    else $error("software compare moved the pin");

  trig_a: assert property (cmpHit && mode == MODE_KTRIG
                           |=> specialTrig_r == !$past(timer1Write))
    else $error("special trigger wrong");

  pwm_buf_a: assert property (sPwmStart |=> valHi_r == $past(valLo_r)
                              && dutySlave_r == $past(dutyNew))
    else $error("pwm buffer not loaded at cycle start");

endmodule

/* File: src/ccp_pkg.sv */
// constants and carrier types of the capture/compare/pwm unit with timer2
package ccp_pkg;

  // ==========================================================
  // register indices (byte address is four times the index)
  localparam logic [7:0] IDX_FLAGS  = 8'h0C;
  localparam logic [7:0] IDX_T2CNT  = 8'h11;
  localparam logic [7:0] IDX_T2CTL  = 8'h12;
  localparam logic [7:0] IDX_VALLO  = 8'h15;
  localparam logic [7:0] IDX_VALHI  = 8'h16;
  localparam logic [7:0] IDX_UCTL   = 8'h17;
  localparam logic [7:0] IDX_ENAB   = 8'h8C;
  localparam logic [7:0] IDX_T2PER  = 8'h92;

  // ==========================================================
  // field positions
  localparam int FLAG_T2_BIT   = 1;
  localparam int FLAG_UNIT_BIT = 2;
  localparam int T2_ON_BIT     = 2;
  localparam int T2_POST_LSB   = 3;
  localparam int UCTL_DUTY_LSB = 4;

  // ==========================================================
  // reset values
  localparam logic [7:0] RST_BYTE  = 8'h00;
  localparam logic [7:0] RST_T2PER = 8'hFF;

  // ==========================================================
  // prescaler tops in oscillator clocks: 4 per count times 1, 4, 16
  localparam int OSC_PER_INSN = 4;
  localparam logic [5:0] PRE_TOP_1  = 6'(OSC_PER_INSN * 1 - 1);
  localparam logic [5:0] PRE_TOP_4  = 6'(OSC_PER_INSN * 4 - 1);
  localparam logic [5:0] PRE_TOP_16 = 6'(OSC_PER_INSN * 16 - 1);
  localparam logic [3:0] CAP_TOP_4  = 4'h3;
  localparam logic [3:0] CAP_TOP_16 = 4'hF;

  // ==========================================================
  // unit mode codes
  localparam logic [3:0] MODE_OFF   = 4'h0;
  localparam logic [3:0] MODE_CFALL = 4'h4;
  localparam logic [3:0] MODE_CRISE = 4'h5;
  localparam logic [3:0] MODE_CR4   = 4'h6;
  localparam logic [3:0] MODE_CR16  = 4'h7;
  localparam logic [3:0] MODE_KSET  = 4'h8;
  localparam logic [3:0] MODE_KCLR  = 4'h9;
  localparam logic [3:0] MODE_KSOFT = 4'hA;
  localparam logic [3:0] MODE_KTRIG = 4'hB;

  // classic wishbone request from the master
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [9:0]  adr;
    logic [31:0] dat;
  } ccp_wb_req_t;

endpackage

/* File: test/ccp_far_end.sv */
// far-side model: timer1 in timer mode and the shared unit pin
`timescale 1ns/1ps
module ccp_far_end (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // timer1 control from the bench
  input  wire logic        run,
  input  wire logic        load,
  input  wire logic [15:0] loadVal,
  input  wire logic        trig,
  output      logic [15:0] count_r,
  // pin sharing
  input  wire logic        pinSrc,
  input  wire logic        pinOut,
  input  wire logic        pinDrive,
  output      logic        pinLevel
);
  // timer mode: one step per clock, so the count is always synchronous
  always_ff @(posedge clk) begin
    if (reset) begin
      count_r <= 16'h0000;
    end else if (load) begin
      count_r <= loadVal;
    end else if (trig) begin
      count_r <= 16'h0000;
    end else if (run) begin
      count_r <= count_r + 16'h0001;
    end
  end

  // the unit latch owns the wire while it drives, else port writes loop back
  assign pinLevel = pinDrive ? pinOut : pinSrc;
endmodule

/* File: test/tb.sv */
// self-checking bench for the capture/compare/pwm unit
`timescale 1ns/1ps
module tb;
  import ccp_pkg::*;
  // ==========================================================
  // stimulus and observation
  logic        clk = 1'h0;
  logic        reset;
  ccp_wb_req_t req;
  logic        ack;
  logic [31:0] dat;
  logic [15:0] t1;
  logic        t1Run;
  logic        t1Load;
  logic [15:0] t1Val;
  logic        trig;
  logic        pinSrc;
  logic        pinOut;
  logic        pinDrv;
  logic        pinLvl;
  logic        t2m;
  logic [7:0]  flags;
  logic [7:0]  enab;
  int          nMismatch = 0;
  int          samplesChecked = 0;

  ccp_unit u_dut (.clk(clk), .reset(reset), .wbReq(req), .wbAck_r(ack),
    .wbDat_r(dat), .timer1Count(t1), .timer1Write(t1Load),
    .specialTrig_r(trig), .unitPinIn(pinLvl), .unitPinOut_r(pinOut),
    .unitPinDrive_r(pinDrv), .t2Match_r(t2m), .flags_r(flags),
    .enables_r(enab));

  ccp_far_end u_far (.clk(clk), .reset(reset), .run(t1Run), .load(t1Load),
    .loadVal(t1Val), .trig(trig), .count_r(t1), .pinSrc(pinSrc),
    .pinOut(pinOut), .pinDrive(pinDrv), .pinLevel(pinLvl));

  // 40 MHz
  always #12.5 clk = ~clk;

  // ==========================================================
  // shared helpers
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samplesChecked, nMismatch);
    if (nMismatch == 0 && samplesChecked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      nMismatch++;
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  // one classic cycle; the request is held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] idx,
                    input logic [7:0] d, output logic [7:0] q);
    int n;
    @(posedge clk);
    req <= '{cyc: 1'h1, stb: 1'h1, we: w, sel: 4'hF,
             adr: {idx, 2'h0}, dat: {24'h0, d}};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'h1 && n < 20);
    if (n >= 20) chk(32'h0, 32'h1);
    q = dat[7:0];
    req.cyc <= 1'h0;
    req.stb <= 1'h0;
    // one idle edge, so whatever the access changed has landed on return
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] q;
    wb(1'h1, idx, d, q);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] q;
    wb(1'h0, idx, 8'h00, q);
    chk(q, exp);
  endtask

  function automatic logic pick(input int s);
    case (s)
      0: return t2m;
      1: return flags[FLAG_UNIT_BIT];
      2: return pinOut;
      default: return ~pinOut;
    endcase
  endfunction

  // bounded poll; n counts the edges that passed
  task automatic waitFor(input int s, input int lim, output int n);
    n = 0;
    while (pick(s) !== 1'h1 && n < lim) begin
      @(posedge clk);
      n++;
    end
    if (n >= lim) chk(32'h0, 32'h1);
  endtask

  task automatic load(input logic [15:0] v, input logic hold);
    @(posedge clk);
    t1Load <= 1'h1;
    t1Val  <= v;
    @(posedge clk);
    t1Load <= hold;
  endtask

  // pulses wider than the pin synchroniser needs
  task automatic pulse();
    pinSrc <= 1'h1;
    repeat (4) @(posedge clk);
    pinSrc <= 1'h0;
    repeat (6) @(posedge clk);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset();
    logic [7:0] idx [8] = '{IDX_FLAGS, IDX_T2CNT, IDX_T2CTL, IDX_VALLO,
                            IDX_VALHI, IDX_UCTL, IDX_ENAB, 8'h13};
    int i;
    rd(IDX_T2PER, RST_T2PER);
    for (i = 0; i < 8; i++) begin
      rd(idx[i], RST_BYTE);
    end
    wr(IDX_ENAB, 8'hFF);
    rd(IDX_ENAB, 8'h06);
    chk(enab, 8'h06);
    wr(IDX_VALLO, 8'hA5);
    wr(IDX_VALHI, 8'h5A);
    rd(IDX_VALLO, 8'hA5);
    rd(IDX_VALHI, 8'h5A);
    wr(8'h13, 8'h77);
    rd(8'h13, 8'h00);
  endtask

  task automatic t_timer2();
    int n;
    int k;
    wr(IDX_T2PER, 8'h03);
    wr(IDX_T2CNT, 8'h00);
    wr(IDX_FLAGS, 8'h00);
    wr(IDX_T2CTL, 8'h0C);
    waitFor(0, 300, n);
    repeat (3) @(posedge clk);
    chk(flags[FLAG_T2_BIT], 1'h0);
    waitFor(0, 300, n);
    repeat (3) @(posedge clk);
    chk(flags[FLAG_T2_BIT], 1'h1);
    // match spacing for each prescale choice
    for (k = 0; k < 3; k++) begin
      wr(IDX_T2CTL, 8'h04 | 8'(k));
      waitFor(0, 5000, n);
      @(posedge clk);
      waitFor(0, 5000, n);
      chk(n + 1, 16 << (2 * k));
    end
    wr(IDX_T2CTL, 8'h00);
    wr(IDX_T2CNT, 8'h05);
    repeat (20) @(posedge clk);
    rd(IDX_T2CNT, 8'h05);
  endtask

  task automatic t_capture();
    logic [3:0] md [4] = '{MODE_CFALL, MODE_CRISE, MODE_CR4, MODE_CR16};
    int         cnt [4] = '{1, 1, 4, 16};
    int         i;
    int         m;
    logic [15:0] v;
    for (m = 0; m < 4; m++) begin
      v = 16'h1357 + 16'(m * 273);
      load(v, 1'h0);
      wr(IDX_UCTL, 8'h00);
      wr(IDX_UCTL, {4'h0, md[m]});
      wr(IDX_FLAGS, 8'h00);
      for (i = 0; i < cnt[m]; i++) begin
        chk(flags[FLAG_UNIT_BIT], 1'h0);
        pulse();
      end
      chk(flags[FLAG_UNIT_BIT], 1'h1);
      rd(IDX_VALLO, v[7:0]);
      rd(IDX_VALHI, v[15:8]);
    end
  endtask

  task automatic t_compare();
    logic [3:0] md [5] = '{MODE_KSET, MODE_KSOFT, MODE_KCLR, MODE_KSET,
                           MODE_KTRIG};
    logic       pin [5] = '{1'h1, 1'h1, 1'h0, 1'h1, 1'h1};
    int         m;
    int         n;
    int         trigs;
    wr(IDX_UCTL, 8'h00);
    wr(IDX_VALLO, 8'h40);
    wr(IDX_VALHI, 8'h00);
    t1Run <= 1'h1;
    for (m = 0; m < 5; m++) begin
      wr(IDX_UCTL, {4'h0, md[m]});
      wr(IDX_FLAGS, 8'h00);
      load(16'h0000, 1'h0);
      waitFor(1, 200, n);
      chk(trig, 32'(md[m] == MODE_KTRIG));
      repeat (2) @(posedge clk);
      chk(pinOut, pin[m]);
    end
    // a timer1 write in the match cycle keeps the trigger quiet
    t1Run <= 1'h0;
    load(16'h0000, 1'h0);
    wr(IDX_FLAGS, 8'h00);
    load(16'h0040, 1'h1);
    trigs = 0;
    repeat (20) begin
      @(posedge clk);
      trigs += int'(trig);
    end
    t1Load <= 1'h0;
    chk(trigs, 0);
    chk(flags[FLAG_UNIT_BIT], 1'h1);
    wr(IDX_UCTL, 8'h00);
    chk(pinOut, 1'h0);
  endtask

  task automatic t_pwm();
    logic [7:0] lo [2] = '{8'h01, 8'h02};
    logic [1:0] dl [2] = '{2'h2, 2'h0};
    int         k;
    int         n;
    int         hi;
    wr(IDX_T2CNT, 8'h00);
    wr(IDX_T2PER, 8'h03);
    wr(IDX_T2CTL, 8'h04);
    for (k = 0; k < 2; k++) begin
      wr(IDX_VALLO, lo[k]);
      wr(IDX_UCTL, {2'h0, dl[k], 4'hC});
      // let one cycle start latch the new duty before measuring
      waitFor(3, 100, n);
      waitFor(2, 100, n);
      @(posedge clk);
      waitFor(3, 100, n);
      waitFor(2, 100, n);
      @(posedge clk);
      waitFor(3, 100, n);
      hi = n + 1;
      @(posedge clk);
      waitFor(2, 100, n);
      chk(hi, {lo[k], dl[k]});
      chk(hi + n + 1, 16);
      chk(pinDrv, 1'h1);
    end
    wr(IDX_VALHI, 8'h55);
    rd(IDX_VALHI, 8'h02);
    wr(IDX_UCTL, 8'h00);
    chk(pinOut, 1'h0);
  endtask

  // ==========================================================
  // main sequence and watchdog
  initial begin
    reset  = 1'h1;
    req    = '0;
    t1Run  = 1'h0;
    t1Load = 1'h0;
    t1Val  = 16'h0000;
    pinSrc = 1'h0;
    repeat (5) @(posedge clk);
    reset <= 1'h0;
    t_reset();
    t_timer2();
    t_capture();
    t_compare();
    t_pwm();
    finish_test();
  end

  initial begin
    #2000000;
    nMismatch++;
    finish_test();
  end
endmodule
